// >>> sapc_host_model.sv
// Purpose: Far-side model: host conversion clock and comparator.
// Assumes: Clock phases built from ref_clk_in cycles.
// Notes: Comparator keeps a trial bit while code is at or below target.
`timescale 1ns/10ps
module sapc_host_model #(
    parameter int HALF_CYC = 5
) (
    input wire logic ref_clk_in,
    input wire logic [15:0] target_in,
    input wire logic [15:0] dac_code_in,
    output logic conv_clk_out,
    output logic comp_out
);
    // Phase counter of the conversion clock
    int phase_cnt = 0;
    // Conversion clock level, one driver only
    logic conv_clk_q = 1'b0;
    // Free-running clock, 200 ns period, 100 ns phases
    always @(negedge ref_clk_in) begin
        if (phase_cnt == HALF_CYC - 1) begin
            phase_cnt <= 0;
            conv_clk_q <= ~conv_clk_q;
        end else begin
            phase_cnt <= phase_cnt + 1;
        end
    end
    assign conv_clk_out = conv_clk_q;
    // Ideal comparator against an offset-binary target
    assign comp_out = (dac_code_in <= target_in);
endmodule

// >>> sapc_pkg.sv
// Purpose: Shared constants and types for the converter control port.
// Assumes: System clock 50 MHz; host pins synchronous to it.
// Notes: Timing, latch, reset and filler numbers of the block live here.
package sapc_pkg;
    // System clock period
    localparam int CLK_PERIOD_NS = 20;
    // Result width
    localparam int RES_W = 16;
    // Resolving edges per conversion
    localparam int CONV_EDGES = 16;
    // Edge count on which the result is latched
    localparam logic [4:0] LATCH_EDGE = 5'h11;
    // Data valid time after strobe falls
    localparam int DATA_VALID_NS = 40;
    // Longest data delay in system cycles, rounded down
    localparam int DATA_VALID_CYC = (DATA_VALID_NS / CLK_PERIOD_NS) < 1 ?
        1 : (DATA_VALID_NS / CLK_PERIOD_NS);
    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] SAR_RST = 16'h0000;
    // Filler on the upper lanes during byte reads
    localparam logic [7:0] UPPER_FILL = 8'h00;
    // Control state of the converter
    typedef enum logic [1:0] {
        SAPC_IDLE,
        SAPC_ARMED,
        SAPC_CONVERT
    } sapc_state_t;
    // Read port pins from the host
    typedef struct packed {
        logic chip_sel_n;
        logic read_strobe_n;
        logic half_word_sel;
    } sapc_rd_port_t;
endpackage

// >>> sapc_port.sv
// Purpose: Conversion control and parallel read port of a 16-bit SAR.
// Assumes: Host conversion clock and start strobe sampled by ref_clk_in; read strobe drives the bus enable directly.
// Notes: Comparator decides each trial code held on dac_code_out.
`timescale 1ns/10ps
module sapc_port (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic conv_clk_in,
    input wire logic conv_start_n_in,
    input wire sapc_pkg::sapc_rd_port_t rd_port_in,
    input wire logic comp_in,
    output logic hold_out,
    output logic busy_out,
    output logic [15:0] dac_code_out,
    output logic [15:0] out_bus_out,
    output logic out_bus_oe_out
);
    // Registers
    sapc_pkg::sapc_state_t state_q; // Converter state
    logic conv_clk_prev_q; // Last conversion clock level
    logic start_prev_q; // Last start level
    logic [4:0] edge_cnt_q; // Conversion edges seen
    logic [15:0] sar_q; // Trial and decided bits
    logic [15:0] result_q; // Output register
    logic [15:0] out_q; // Registered bus data
    logic busy_q; // Busy flag
    logic hold_q; // Hold switch state
    // Events
    logic conv_rise; // Conversion clock rising edge
    logic start_fall; // Start falling edge
    logic start_ok; // Accepted start
    logic latch_evt; // Result latch edge
    logic [3:0] bit_idx; // Bit being decided

    // Rising edge of the host clock
    assign conv_rise = conv_clk_in & ~conv_clk_prev_q;
    // Falling edge of the start strobe
    assign start_fall = ~conv_start_n_in & start_prev_q;
    // Accept only with select low and no conversion running
    assign start_ok = start_fall & ~rd_port_in.chip_sel_n &
        (state_q == sapc_pkg::SAPC_IDLE);
    // Seventeenth edge ends the conversion
    assign latch_evt = (state_q == sapc_pkg::SAPC_CONVERT) & conv_rise &
        (edge_cnt_q == (sapc_pkg::LATCH_EDGE - 5'h01));
    // Bit decided on edge n+1 is bit 16-n
    assign bit_idx = 4'(5'h10 - edge_cnt_q);

    // Edge detector history
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            conv_clk_prev_q <= 1'b0;
            start_prev_q <= 1'b1;
        end else begin
            conv_clk_prev_q <= conv_clk_in;
            start_prev_q <= conv_start_n_in;
        end
    end

    // Converter sequencing
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_q <= sapc_pkg::SAPC_IDLE;
            edge_cnt_q <= 5'h00;
        end else begin
            unique case (state_q)
                // Waiting for a start
                sapc_pkg::SAPC_IDLE: begin
                    if (start_ok) begin
                        state_q <= sapc_pkg::SAPC_ARMED;
                        edge_cnt_q <= 5'h00;
                    end
                end
                // First rising edge is cycle one
                sapc_pkg::SAPC_ARMED: begin
                    if (conv_rise) begin
                        state_q <= sapc_pkg::SAPC_CONVERT;
                        edge_cnt_q <= 5'h01;
                    end
                end
                // Sixteen decisions then latch
                sapc_pkg::SAPC_CONVERT: begin
                    if (latch_evt) begin
                        // Ready for the next frame right after the latch
                        state_q <= sapc_pkg::SAPC_IDLE;
                        edge_cnt_q <= 5'h00;
                    end else if (conv_rise) begin
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                    end
                end
                // Unused code falls back to waiting
                default: begin
                    state_q <= sapc_pkg::SAPC_IDLE;
                    edge_cnt_q <= 5'h00;
                end
            endcase
        end
    end

    // Successive approximation register
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            sar_q <= sapc_pkg::SAR_RST;
        end else if (state_q == sapc_pkg::SAPC_ARMED && conv_rise) begin
            // Cycle one puts the first trial
            sar_q <= 16'h8000;
        end else if (state_q == sapc_pkg::SAPC_CONVERT && conv_rise) begin
            // Keep or drop the trial bit, then try the next one
            sar_q[bit_idx] <= comp_in;
            if (bit_idx != 4'h0) begin
                sar_q[bit_idx - 4'h1] <= 1'b1;
            end
        end
    end

    // Output register in two's complement
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            result_q <= sapc_pkg::RESULT_RST;
        end else if (latch_evt) begin
            // Offset binary to two's complement, last bit included
            result_q <= {~sar_q[15], sar_q[14:1], comp_in};
        end
    end

    // Busy flag
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
        end else if (start_ok) begin
            busy_q <= 1'b1;
        end else if (latch_evt) begin
            busy_q <= 1'b0;
        end
    end

    // Sample and hold switch
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            hold_q <= 1'b0;
        end else if (start_ok) begin
            hold_q <= 1'b1;
        end else if (latch_evt) begin
            hold_q <= 1'b0;
        end
    end

    // Bus data, whole word or upper byte on low lanes
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            out_q <= sapc_pkg::RESULT_RST;
        end else if (rd_port_in.half_word_sel) begin
            out_q <= {sapc_pkg::UPPER_FILL, result_q[15:8]};
        end else begin
            out_q <= result_q;
        end
    end

    // Drivers
    assign out_bus_oe_out = ~rd_port_in.chip_sel_n &
        ~rd_port_in.read_strobe_n;
    assign out_bus_out = out_q;
    assign busy_out = busy_q;
    assign hold_out = hold_q;
    assign dac_code_out = sar_q;

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    // Start then busy in the next cycle
    sequence s_started;
        start_ok ##1 busy_out;
    endsequence

    // Rises seen since the accepted start, kept apart from the sequencer
    logic [4:0] rise_seen_q;

    // Independent count of conversion clock rises while busy
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in || start_ok) begin
            rise_seen_q <= 5'h00;
        end else if (busy_q && conv_rise && rise_seen_q != 5'h1f) begin
            rise_seen_q <= rise_seen_q + 5'h01;
        end
    end

    a_busy_on_start: assert property (
        start_ok |=> busy_out && hold_out)
        else $error("busy or hold missing after start");
    a_hold_on_start: assert property (
        s_started |-> hold_out)
        else $error("hold not entered at start");
    a_no_start_cs: assert property (
        start_fall && rd_port_in.chip_sel_n && !busy_out |=> !busy_out)
        else $error("start accepted with select high");
    a_cycle_one: assert property (
        state_q == sapc_pkg::SAPC_ARMED && conv_rise
        |=> edge_cnt_q == 5'h01 && sar_q == 16'h8000)
        else $error("first edge not cycle one");
    a_rise_count: assert property (
        busy_q && conv_rise
        |-> latch_evt == (rise_seen_q == 5'h10))
        else $error("latch not on seventeenth rise");
    a_latch_edge: assert property (
        latch_evt |=> !busy_out && !hold_out
        && $past(edge_cnt_q) == 5'(sapc_pkg::CONV_EDGES))
        else $error("latch not on seventeenth edge");
    a_busy_fall_cause: assert property (
        $fell(busy_out) |-> $past(latch_evt))
        else $error("busy fell without latch");
    a_ignore_restart: assert property (
        busy_out && start_fall && !latch_evt
        |=> busy_out && $stable(result_q))
        else $error("restart during conversion");
    a_twos_comp: assert property (
        latch_evt |=> result_q ==
        {~$past(sar_q[15]), $past(sar_q[14:1]), $past(comp_in)})
        else $error("result format wrong");
    a_oe_decode: assert property (
        out_bus_oe_out == (!rd_port_in.chip_sel_n
        && !rd_port_in.read_strobe_n))
        else $error("bus enable decode wrong");
    a_byte_lanes: assert property (
        rd_port_in.half_word_sel ##1 $stable(result_q)
        |-> out_bus_out == {sapc_pkg::UPPER_FILL, result_q[15:8]})
        else $error("upper byte not on low lanes");
    // A latch in the strobe cycle itself changes the word, so skip it
    a_data_valid: assert property (
        $fell(rd_port_in.read_strobe_n) && !rd_port_in.half_word_sel
        ##1 !rd_port_in.half_word_sel && $stable(result_q)
        |-> out_bus_out == result_q)
        else $error("bus data late");
endmodule

// >>> sar_adc_parallel_conversion_port_tb.sv
// Purpose: Self-checking bench for the converter control port.
// Assumes: Inputs change on the falling edge of ref_clk_in.
// Notes: Results given as two's complement; target is offset binary.
`timescale 1ns/10ps
module sar_adc_parallel_conversion_port_tb;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic conv_start_n_in = 1'b1;
    sapc_pkg::sapc_rd_port_t rd_port = 3'b110;
    logic [15:0] target = 16'h0000;
    logic conv_clk, comp, hold_out, busy_out, out_bus_oe_out;
    logic [15:0] dac_code, out_bus_out;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    // System clock, 50 MHz
    always #10 ref_clk_in = ~ref_clk_in;
    sapc_host_model host (.ref_clk_in(ref_clk_in), .target_in(target),
        .dac_code_in(dac_code), .conv_clk_out(conv_clk), .comp_out(comp));
    sapc_port dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .conv_clk_in(conv_clk), .conv_start_n_in(conv_start_n_in),
        .rd_port_in(rd_port), .comp_in(comp), .hold_out(hold_out),
        .busy_out(busy_out), .dac_code_out(dac_code),
        .out_bus_out(out_bus_out), .out_bus_oe_out(out_bus_oe_out));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            final_report();
        end
    end
    // Start refused while select is high; bus stays off
    task automatic start_unselected();
        @(negedge ref_clk_in);
        rd_port = 3'b100;
        conv_start_n_in = 1'b0;
        repeat (5) @(negedge ref_clk_in);
        check(busy_out, 1'b0);
        check(out_bus_oe_out, 1'b0);
        conv_start_n_in = 1'b1;
        rd_port = 3'b110;
    endtask
    // Full frame: start, ignored restart, busy wait, word and byte reads
    task automatic run_conv(input logic [15:0] code);
        int n;
        target = code ^ 16'h8000;
        @(negedge ref_clk_in);
        rd_port.chip_sel_n = 1'b0;
        conv_start_n_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(hold_out, 1'b1);
        check(busy_out, 1'b1);
        conv_start_n_in = 1'b1;
        rd_port.chip_sel_n = 1'b1;
        repeat (20) @(negedge ref_clk_in);
        check(out_bus_oe_out, 1'b0);
        // Restart with select low, must still be ignored
        rd_port.chip_sel_n = 1'b0;
        conv_start_n_in = 1'b0;
        @(negedge ref_clk_in);
        conv_start_n_in = 1'b1;
        n = 23;
        while (busy_out === 1'b1 && n < 400) begin
            @(negedge ref_clk_in);
            n++;
        end
        // First counted rise 1 to 10 cycles after start, then 16 periods
        check(n >= 162 && n <= 171, 1'b1);
        check(hold_out, 1'b0);
        rd_port.read_strobe_n = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(out_bus_oe_out, 1'b1);
        check(out_bus_out, code);
        rd_port.half_word_sel = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        check(out_bus_out, {8'h00, code[15:8]});
        // Strobe stays low while the select goes back
        rd_port.half_word_sel = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(out_bus_out[7:0], code[7:0]);
        rd_port = 3'b110;
        @(negedge ref_clk_in);
        check(out_bus_oe_out, 1'b0);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        @(negedge ref_clk_in);
        check(busy_out, 1'b0);
        start_unselected();
        run_conv(16'h7fff);
        run_conv(16'h8000);
        run_conv(16'h0000);
        run_conv(16'hffff);
        run_conv(16'h5a3c);
        final_report();
    end
endmodule
